/* core/uscf_top.sv */
// Control and status flags of an asynchronous serial port behind an AHB-Lite slave.
// Assumes one 10 MHz clock; rxd comes straight from a pin and is synchronised here.
`timescale 1ns/1ns
`default_nettype none
module uscf_top
  import uscf_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial link
  input  wire logic        rxd,
  output logic             txd,
  output logic             txd_oe,
  // Interrupt request
  output logic             irq
);

  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    return a == {22'h0, idx, 2'h0};
  endfunction : hit

  function automatic logic [3:0] flen(input logic nine);
    return FRAME_BITS + {3'h0, nine};
  endfunction : flen

  function automatic logic [7:0] qlast(input logic nine);
    return 8'(int'(flen(nine)) * int'(BIT_CYC) - 1);
  endfunction : qlast

  function automatic logic [3:0] blen(input logic nine, input logic long_brk);
    return flen(nine) + (long_brk ? BRK_EXTRA : 4'h0);
  endfunction : blen

  // Bus
  logic        take;
  logic        rd_stat;
  logic        rd_data;
  logic        wr_data;
  logic        wr_ctrl;
  logic        wr_cfg;
  logic        wr_pend;
  logic        next_wr_pend;
  logic [31:0] wr_addr;
  logic [31:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic        next_hreadyout;
  // Control and flags
  logic [7:0]  ctrl;
  logic [7:0]  next_ctrl;
  logic [1:0]  cfg;
  logic [1:0]  next_cfg;
  logic [7:0]  stat;
  logic [7:0]  seen;
  logic [7:0]  next_seen;
  logic        tx_buffer_empty;
  logic        next_tx_buffer_empty;
  logic        tc;
  logic        next_tc;
  logic        rx_buffer_full;
  logic        next_rx_buffer_full;
  logic        idle;
  logic        next_idle;
  logic        ovr;
  logic        next_ovr;
  logic        armed;
  logic        next_armed;
  logic        quiet_prev;
  logic        tx_quiet;
  logic        next_irq;
  logic        nine;
  logic        stby;
  // Transmitter
  uscf_tx_t    tx_state;
  uscf_tx_t    next_tx_state;
  logic [13:0] tx_shift;
  logic [13:0] next_tx_shift;
  logic [3:0]  tx_left;
  logic [3:0]  next_tx_left;
  logic [4:0]  tx_tick;
  logic [4:0]  next_tx_tick;
  logic [7:0]  tx_buf;
  logic [7:0]  next_tx_buf;
  logic        te_prev;
  logic        pre_pend;
  logic        next_pre_pend;
  logic        tx_load;
  logic        tx_frame;
  logic        next_txd;
  logic        next_txd_oe;
  // Receiver
  logic        rx_s1;
  logic        rxs;
  uscf_rx_t    rx_state;
  uscf_rx_t    next_rx_state;
  logic [4:0]  rx_tick;
  logic [4:0]  next_rx_tick;
  logic [3:0]  rx_cnt;
  logic [3:0]  next_rx_cnt;
  logic [8:0]  rx_shift;
  logic [8:0]  next_rx_shift;
  logic [7:0]  rx_data;
  logic [7:0]  next_rx_data;
  logic        rx_done;
  logic [7:0]  q_cnt;
  logic [7:0]  next_q_cnt;
  logic        q_hit;

  assign nine = cfg[CF_NINE];
  assign stby = ctrl[CR_STBY];

  // Bus: reads answer with no wait; a write holds hready low one cycle so a
  // following read always sees the updated registers.
  always_comb begin
    take = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
    rd_stat = take & !hwrite & hit(haddr, IDX_STAT);
    rd_data = take & !hwrite & hit(haddr, IDX_DATA);
    wr_data = wr_pend & hit(wr_addr, IDX_DATA);
    wr_ctrl = wr_pend & hit(wr_addr, IDX_CTRL);
    wr_cfg = wr_pend & hit(wr_addr, IDX_CFG);
    next_wr_pend = take & hwrite;
    next_wr_addr = (take & hwrite) ? haddr : wr_addr;
    next_hreadyout = !(take & hwrite);
    next_hrdata = hrdata;
    if (take & !hwrite) begin
      if (hit(haddr, IDX_CTRL)) begin
        next_hrdata = {24'h0, ctrl};
      end else if (hit(haddr, IDX_STAT)) begin
        next_hrdata = {24'h0, stat};
      end else if (hit(haddr, IDX_DATA)) begin
        next_hrdata = {24'h0, rx_data};
      end else if (hit(haddr, IDX_CFG)) begin
        next_hrdata = {30'h0, cfg};
      end else begin
        next_hrdata = 32'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp <= 1'b0;
    end
  end

  // Control, configuration and flag clearing; status has no write path [R12]
  always_comb begin
    stat = 8'h00;
    stat[SR_TX_BUFFER_EMPTY] = tx_buffer_empty;
    stat[SR_TC] = tc;
    stat[SR_RX_BUFFER_FULL] = rx_buffer_full;
    stat[SR_IDLE] = idle;
    stat[SR_OVR] = ovr;
    next_ctrl = ctrl;
    if (q_hit & stby) begin
      next_ctrl[CR_STBY] = 1'b0; // [R8]
    end
    if (wr_ctrl) begin
      next_ctrl = hwdata[7:0]; // [R5] [R6] [R7] [R9]
    end
    next_cfg = wr_cfg ? hwdata[1:0] : cfg; // [R25] [R26]
    next_seen = seen;
    if (rd_stat) begin
      next_seen = stat; // [R11]
    end else if (rd_data | wr_data) begin
      next_seen = 8'h00;
    end
    tx_quiet = (tx_state == USCF_TX_IDLE) & !tx_load & tx_buffer_empty;
    next_tx_buffer_empty = tx_buffer_empty;
    if (seen[SR_TX_BUFFER_EMPTY] & wr_data) begin
      next_tx_buffer_empty = 1'b0; // [R14]
    end
    if (tx_frame) begin
      next_tx_buffer_empty = 1'b1; // [R13]
    end
    next_tc = tc;
    if (seen[SR_TC] & wr_data) begin
      next_tc = 1'b0; // [R17]
    end
    if (tx_quiet & !quiet_prev) begin
      next_tc = 1'b1; // [R16]
    end
    if (tx_load) begin
      next_tc = 1'b0; // [R15] [R17]
    end
    next_rx_buffer_full = rx_buffer_full;
    next_ovr = ovr;
    next_idle = idle;
    next_armed = armed;
    next_rx_data = rx_data;
    if (seen[SR_RX_BUFFER_FULL] & rd_data) begin
      next_rx_buffer_full = 1'b0; // [R19]
    end
    if (seen[SR_OVR] & rd_data) begin
      next_ovr = 1'b0;
    end
    if (seen[SR_IDLE] & rd_data) begin
      next_idle = 1'b0; // [R22]
    end
    if (q_hit & !stby & armed) begin
      next_idle = 1'b1; // [R20] [R23]
      next_armed = 1'b0;
    end
    if (rx_done & !stby) begin
      if (rx_buffer_full) begin
        next_ovr = 1'b1; // [R24]
      end else begin
        next_rx_buffer_full = 1'b1; // [R18]
        next_armed = 1'b1; // [R21]
        next_rx_data = nine ? rx_shift[7:0] : rx_shift[8:1];
      end
    end
    next_irq = (ctrl[CR_TIE] & tx_buffer_empty) // [R1]
             | (ctrl[CR_TX_DONE_IRQ_ON] & tc) // [R2]
             | (ctrl[CR_RIE] & (rx_buffer_full | ovr) & !stby) // [R3] [R7]
             | (ctrl[CR_QUIET_IRQ_ON] & idle & !stby); // [R4] [R27]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RST;
      cfg <= CFG_RST;
      seen <= 8'h00;
      tx_buffer_empty <= 1'b1;
      tc <= 1'b1;
      quiet_prev <= 1'b1;
      rx_buffer_full <= 1'b0;
      ovr <= 1'b0;
      idle <= 1'b0;
      armed <= 1'b1;
      rx_data <= 8'h00;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      cfg <= next_cfg;
      seen <= next_seen;
      tx_buffer_empty <= next_tx_buffer_empty;
      tc <= next_tc;
      quiet_prev <= tx_quiet;
      rx_buffer_full <= next_rx_buffer_full;
      ovr <= next_ovr;
      idle <= next_idle;
      armed <= next_armed;
      rx_data <= next_rx_data;
      irq <= next_irq;
    end
  end

  // Transmitter: a preamble wins over a break, a break over data.
  // A shift in progress always completes, even if the enable drops.
  always_comb begin
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_left = tx_left;
    next_tx_tick = tx_tick;
    next_pre_pend = pre_pend | (ctrl[CR_TE] & !te_prev); // [R5]
    next_tx_buf = wr_data ? hwdata[7:0] : tx_buf;
    tx_load = 1'b0;
    tx_frame = 1'b0;
    unique case (tx_state)
      USCF_TX_IDLE: begin
        if (ctrl[CR_TE] & (pre_pend | ctrl[CR_SBK] | !tx_buffer_empty)) begin
          tx_load = 1'b1;
          next_tx_state = USCF_TX_RUN;
          next_tx_tick = BIT_LAST;
          next_tx_left = flen(nine);
          if (pre_pend) begin
            next_tx_shift = '1; // [R5]
            next_pre_pend = 1'b0;
          end else if (ctrl[CR_SBK]) begin
            next_tx_shift = '0; // [R9] [R10]
            next_tx_left = blen(nine, cfg[CF_LONG]); // [R25]
          end else begin
            next_tx_shift = {4'hF, !nine, tx_buf, 1'b0}; // [R26]
            tx_frame = 1'b1;
          end
        end
      end
      USCF_TX_RUN: begin
        if (tx_tick == 5'h0) begin
          next_tx_tick = BIT_LAST;
          next_tx_shift = {1'b1, tx_shift[13:1]};
          next_tx_left = tx_left - 4'h1;
          if (tx_left == 4'h1) begin
            // A held break chains on with no high gap between characters
            if (ctrl[CR_TE] & ctrl[CR_SBK] & !pre_pend) begin
              tx_load = 1'b1;
              next_tx_shift = '0; // [R10]
              next_tx_left = blen(nine, cfg[CF_LONG]); // [R25]
            end else begin
              next_tx_state = USCF_TX_IDLE;
            end
          end
        end else begin
          next_tx_tick = tx_tick - 5'h1;
        end
      end
    endcase
    next_txd = (next_tx_state == USCF_TX_RUN) ? next_tx_shift[0] : 1'b1; // [R16]
    next_txd_oe = ctrl[CR_TE] | (next_tx_state == USCF_TX_RUN); // [R5]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state <= USCF_TX_IDLE;
      tx_shift <= '1;
      tx_left <= 4'h0;
      tx_tick <= 5'h0;
      tx_buf <= 8'h00;
      te_prev <= 1'b0;
      pre_pend <= 1'b0;
      txd <= 1'b1;
      txd_oe <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      tx_shift <= next_tx_shift;
      tx_left <= next_tx_left;
      tx_tick <= next_tx_tick;
      tx_buf <= next_tx_buf;
      te_prev <= ctrl[CR_TE];
      pre_pend <= next_pre_pend;
      txd <= next_txd;
      txd_oe <= next_txd_oe;
    end
  end

  // Receiver: samples mid-bit; stop-bit value is not checked here
  always_comb begin
    next_rx_state = rx_state;
    next_rx_tick = rx_tick;
    next_rx_cnt = rx_cnt;
    next_rx_shift = rx_shift;
    rx_done = 1'b0;
    if (!ctrl[CR_RE]) begin
      next_rx_state = USCF_RX_IDLE; // [R6]
    end else begin
      unique case (rx_state)
        USCF_RX_IDLE: begin
          if (!rxs) begin
            next_rx_state = USCF_RX_START;
            next_rx_tick = HALF_LAST;
          end
        end
        USCF_RX_START: begin
          if (rx_tick != 5'h0) begin
            next_rx_tick = rx_tick - 5'h1;
          end else if (rxs) begin
            next_rx_state = USCF_RX_IDLE;
          end else begin
            next_rx_state = USCF_RX_DATA;
            next_rx_tick = BIT_LAST;
            next_rx_cnt = 4'h0;
          end
        end
        default: begin
          if (rx_tick != 5'h0) begin
            next_rx_tick = rx_tick - 5'h1;
          end else begin
            next_rx_tick = BIT_LAST;
            if (rx_cnt == DATA_BITS + {3'h0, nine}) begin
              next_rx_state = USCF_RX_IDLE;
              rx_done = 1'b1;
            end else begin
              next_rx_shift = {rxs, rx_shift[8:1]};
              next_rx_cnt = rx_cnt + 4'h1;
            end
          end
        end
      endcase
    end
    // Counts line-high cycles; fires once per quiet stretch
    q_hit = ctrl[CR_RE] & rxs & (q_cnt == qlast(nine)); // [R20]
    if (!ctrl[CR_RE] | !rxs) begin
      next_q_cnt = 8'h00;
    end else if (q_cnt > qlast(nine)) begin
      next_q_cnt = q_cnt;
    end else begin
      next_q_cnt = q_cnt + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1 <= 1'b1;
      rxs <= 1'b1;
      rx_state <= USCF_RX_IDLE;
      rx_tick <= 5'h0;
      rx_cnt <= 4'h0;
      rx_shift <= 9'h000;
      q_cnt <= 8'h00;
    end else begin
      rx_s1 <= rxd;
      rxs <= rx_s1;
      rx_state <= next_rx_state;
      rx_tick <= next_rx_tick;
      rx_cnt <= next_rx_cnt;
      rx_shift <= next_rx_shift;
      q_cnt <= next_q_cnt;
    end
  end

endmodule : uscf_top
`default_nettype wire

/* core/uscf_pkg.sv */
// Register map, field positions, timing counts and state types of the serial port
// control/status block. Assumes a 10 MHz bus clock and a fixed bit time of BIT_CYC.
// Functional notes
// (R1) Control bit 7 gates the transmit-buffer-empty flag onto the interrupt request.
// (R2) Control bit 6 gates the transmission-done flag onto the interrupt request.
// (R3) Control bit 5 gates receive-full or overrun onto the interrupt request.
// (R4) Control bit 4 gates the quiet-line flag onto the interrupt request.
// (R5) Control bit 3 enables the transmitter and pin; a rising edge queues a preamble.
// (R6) Control bit 2 turns the receiver on or off.
// (R7) Control bit 1 puts the receiver in standby and masks receiver interrupts.
// (R8) Hardware clears the standby bit itself on wakeup.
// (R9) Pulsing the break bit sends one break of 10/11 or 13/14 zero bits.
// (R10) While the break bit stays set, complete breaks are sent back to back.
// (R11) Software clears a flag by reading status, then accessing the data register.
// (R12) Writes to the status register change nothing.
// (R13) Transmit-empty sets when the shifter takes a byte from the data register.
// (R14) Transmit-empty clears on status read seeing it, then data write.
// (R15) Transmission-done is low while a frame, preamble or break is sent.
// (R16) Transmission-done sets when buffer empty and shifter quiet; pin rests at one.
// (R17) Transmission-done clears on read-then-write, or when anything new is queued.
// (R18) Receive-full sets when a received character moves into the data register.
// (R19) Receive-full clears on status read seeing it, then data read.
// (R20) Quiet-line sets after 10 ones (eight-bit) or 11 ones (nine-bit).
// (R21) After quiet-line clears, a received frame must come before it sets again.
// (R22) Quiet-line clears on status read seeing it, then data read.
// (R23) In standby an idle line does not set the quiet-line flag.
// (R24) Overrun sets when a second frame completes before the first is read.
// (R25) Long-break select picks 13/14-bit breaks instead of 10/11.
// (R26) Format bit picks eight data bits when 0 and nine when 1.
// (R27) Interrupt output is the OR of every flag gated by its enable.
package uscf_pkg;
  localparam int unsigned CLK_HZ    = 10_000_000;
  localparam int unsigned BAUD_HZ   = 625_000;
  localparam int unsigned BIT_CYC   = CLK_HZ / BAUD_HZ;
  localparam logic [4:0]  BIT_LAST  = 5'(BIT_CYC - 1);
  localparam logic [4:0]  HALF_LAST = 5'(BIT_CYC / 2 - 1);
  localparam logic [3:0]  FRAME_BITS = 4'hA;
  localparam logic [3:0]  DATA_BITS  = 4'h8;
  localparam logic [3:0]  BRK_EXTRA  = 4'h3;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CTRL  = 8'h03;
  localparam logic [7:0]  IDX_STAT  = 8'h04;
  localparam logic [7:0]  IDX_DATA  = 8'h07;
  localparam logic [7:0]  IDX_CFG   = 8'h08;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  // Control fields
  localparam int CR_TIE  = 7;
  localparam int CR_TX_DONE_IRQ_ON = 6;
  localparam int CR_RIE  = 5;
  localparam int CR_QUIET_IRQ_ON = 4;
  localparam int CR_TE   = 3;
  localparam int CR_RE   = 2;
  localparam int CR_STBY = 1;
  localparam int CR_SBK  = 0;
  // Status fields
  localparam int SR_TX_BUFFER_EMPTY = 7;
  localparam int SR_TC   = 6;
  localparam int SR_RX_BUFFER_FULL = 5;
  localparam int SR_IDLE = 4;
  localparam int SR_OVR  = 3;
  // Configuration fields
  localparam int CF_NINE = 0;
  localparam int CF_LONG = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] CFG_RST  = 2'h0;
  typedef enum logic [0:0] {USCF_TX_IDLE = 1'b0, USCF_TX_RUN = 1'b1} uscf_tx_t;
  typedef enum logic [1:0] {
    USCF_RX_IDLE  = 2'b00,
    USCF_RX_START = 2'b01,
    USCF_RX_DATA  = 2'b10
  } uscf_rx_t;
endpackage : uscf_pkg

/* bench/uscf_chk.sv */
// Port checker for uscf_top: readback, interrupt level and serial pin timing.
// Assumes word transfers only and hready tied to hreadyout.
`timescale 1ns/1ns
`default_nettype none
module uscf_chk
  import uscf_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // AHB-Lite
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Serial link and request
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        txd_oe,
  input wire logic        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       tk, wc, rs, rc, wp, tq, next_wp;
  logic [7:0] sh, ps, next_sh;
  logic [4:0] run, next_run;
  assign tk = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
  assign wc = tk & hwrite & (haddr[9:2] == IDX_CTRL);
  assign rs = tk & !hwrite & (haddr[9:2] == IDX_STAT);
  assign rc = tk & !hwrite & (haddr[9:2] == IDX_CTRL);
  // Shadow of control; hardware may clear standby, so bit 1 is only trusted at 0
  always_comb begin
    next_wp  = wc;
    next_sh  = wp ? hwdata[7:0] : sh;
    next_run = (txd != tq) ? 5'h00 : run + {4'h0, run != 5'h1F};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wp, sh, ps, tq, run} <= {1'b0, 8'h00, 8'h00, 1'b1, 5'h1F};
    end else begin
      {wp, sh, ps, tq, run} <= {next_wp, next_sh, sh, txd, next_run};
    end
  end
  tie_irq_a: assert property (rs ##1 (ps[7] & hrdata[7]) |-> irq)
    else $error("irq low with tx-empty on");
  tx_done_irq_on_irq_a: assert property (rs ##1 (ps[6] & hrdata[6]) |-> irq)
    else $error("irq low with tx-done on");
  rie_irq_a: assert property (rs ##1 (ps[5] & !ps[1] & (hrdata[5] | hrdata[3])) |-> irq)
    else $error("irq low with rx-full on");
  quiet_irq_on_irq_a: assert property (rs ##1 (ps[4] & !ps[1] & hrdata[4]) |-> irq)
    else $error("irq low with quiet on");
  irq_quiet_a: assert property (rs ##1 ((ps[7:4] & hrdata[7:4]) == 4'h0 && !(ps[5] & hrdata[3])) |-> !irq)
    else $error("irq high with nothing on");
  ctrl_back_a: assert property (rc |=> {hrdata[31:8], hrdata[7:2], hrdata[0]} == {24'h0, ps[7:2], ps[0]})
    else $error("control readback wrong");
  oe_on_a: assert property (wc ##1 hwdata[3] |-> ##[1:2] txd_oe)
    else $error("pin not driven");
  idle_high_a: assert property (!txd_oe |-> txd)
    else $error("released pin low");
  bit_time_a: assert property (txd != tq |-> run >= 5'h0F)
    else $error("serial bit too short");
  cover property (rs ##1 irq);
  cover property (wc ##1 hwdata[0]);
  cover property (rs ##1 hrdata[3]);
endmodule : uscf_chk
bind uscf_top uscf_chk i_uscf_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
  .hready, .hrdata, .hreadyout, .hresp, .rxd, .txd, .txd_oe, .irq
);
`default_nettype wire

/* bench/uscf_peer.sv */
// Serial peer: sends frames on rxd, decodes txd, logs the longest low run.
// Assumes 16 clocks a bit and eight data bits.
`timescale 1ns/1ns
`default_nettype none
module uscf_peer (
  // Clock
  input  wire logic hclk,
  // Link
  input  wire logic txd,
  output var  logic rxd
);
  logic [7:0] got;
  int         low_run = 0;
  int         low_max = 0;
  // Idle line rests high, as with the pin pull-up
  initial rxd = 1'b1;
  // Start low, data LSB first, stop high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge hclk);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (16) @(posedge hclk);
    end
  endtask : send
  // Short low pulse: not a frame, but it restarts the quiet count
  task automatic glitch;
    @(posedge hclk);
    rxd <= 1'b0;
    repeat (3) @(posedge hclk);
    rxd <= 1'b1;
  endtask : glitch
  // Mid-bit sampling; a break simply decodes as zero
  initial forever begin
    @(negedge txd);
    repeat (8) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge hclk);
      got[i] = txd;
    end
  end
  always @(posedge hclk) begin
    low_run <= txd ? 0 : low_run + 1;
    if (low_run > low_max) low_max <= low_run;
  end
endmodule : uscf_peer
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench: AHB-Lite master tasks, serial peer, flag scenarios.
// Assumes the checker binds itself to uscf_top.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import uscf_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        rxd, txd, txd_oe, irq;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          n_mismatch, check_count;
  assign hready = hreadyout;
  uscf_top i_uscf_top (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .rxd, .txd, .txd_oe, .irq
  );
  uscf_peer i_uscf_peer (.hclk, .txd, .rxd);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Single transfer; the slave sets the pace through hready
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    rv = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(rv, e);
  endtask : rdc
  task automatic irqc(input logic e);
    @(negedge hclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : irqc
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task automatic final_report;
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic t_regs;
    rdc(IDX_STAT, 32'hC0);
    rdc(IDX_CTRL, 32'h00);
    wr(IDX_STAT, 32'h00);
    wr(8'h01, 32'hFF);
    rdc(IDX_STAT, 32'hC0);
    rdc(8'h01, 32'h00);
    chk({31'h0, hresp}, 32'h0);
  endtask : t_regs
  task automatic t_irq;
    wr(IDX_CTRL, 32'h80);
    irqc(1'b1);
    rdc(IDX_STAT, 32'hC0);
    wr(IDX_CTRL, 32'h40);
    irqc(1'b1);
    rdc(IDX_STAT, 32'hC0);
    wr(IDX_CTRL, 32'h30);
    irqc(1'b0);
    wr(IDX_CTRL, 32'h00);
    irqc(1'b0);
  endtask : t_irq
  // Preamble first, then the byte; the write follows a status read
  task automatic t_tx;
    wr(IDX_CTRL, 32'h08);
    rdc(IDX_STAT, 32'h80);
    chk({31'h0, txd_oe}, 32'h1);
    wr(IDX_DATA, 32'hA5);
    rdc(IDX_STAT, 32'h00);
    cyc(200);
    rdc(IDX_STAT, 32'h80);
    cyc(200);
    rdc(IDX_STAT, 32'hC0);
    chk({24'h0, i_uscf_peer.got}, 32'hA5);
    chk({31'h0, txd}, 32'h1);
  endtask : t_tx
  task automatic t_brk;
    wr(IDX_CFG, 32'h2);
    i_uscf_peer.low_max = 0;
    wr(IDX_CTRL, 32'h09);
    wr(IDX_CTRL, 32'h08);
    rdc(IDX_STAT, 32'h80);
    cyc(300);
    chk(32'(i_uscf_peer.low_max), 32'd208);
    wr(IDX_CFG, 32'h0);
    i_uscf_peer.low_max = 0;
    wr(IDX_CTRL, 32'h09);
    wr(IDX_CTRL, 32'h08);
    cyc(300);
    chk(32'(i_uscf_peer.low_max), 32'd160);
    i_uscf_peer.low_max = 0;
    wr(IDX_CTRL, 32'h09);
    cyc(400);
    wr(IDX_CTRL, 32'h08);
    cyc(300);
    chk({31'h0, i_uscf_peer.low_max >= 320}, 32'h1);
  endtask : t_brk
  task automatic t_rx;
    wr(IDX_CTRL, 32'h2C);
    cyc(200);
    rdc(IDX_STAT, 32'hD0);
    irqc(1'b0);
    wr(IDX_CTRL, 32'h3C);
    irqc(1'b1);
    i_uscf_peer.send(8'h3C);
    cyc(4);
    rdc(IDX_STAT, 32'hF0);
    rdc(IDX_DATA, 32'h3C);
    rdc(IDX_STAT, 32'hC0);
    cyc(200);
    rdc(IDX_STAT, 32'hD0);
    rdc(IDX_DATA, 32'h3C);
    i_uscf_peer.glitch();
    cyc(200);
    rdc(IDX_STAT, 32'hC0);
    i_uscf_peer.send(8'h11);
    i_uscf_peer.send(8'h22);
    cyc(4);
    rdc(IDX_STAT, 32'hE8);
    irqc(1'b1);
    rdc(IDX_DATA, 32'h11);
    rdc(IDX_STAT, 32'hC0);
    i_uscf_peer.send(8'h33);
    cyc(4);
    rdc(IDX_DATA, 32'h33);
    rdc(IDX_STAT, 32'hE0);
    rdc(IDX_DATA, 32'h33);
  endtask : t_rx
  // Frame in standby is dropped; the idle line that follows ends standby
  task automatic t_stby;
    wr(IDX_CTRL, 32'h2E);
    i_uscf_peer.send(8'h55);
    cyc(4);
    rdc(IDX_STAT, 32'hC0);
    cyc(200);
    rdc(IDX_CTRL, 32'h2C);
    rdc(IDX_STAT, 32'hC0);
  endtask : t_stby
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = HSIZE_WORD;
    n_mismatch = 0;
    check_count = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_irq();
    t_tx();
    t_brk();
    t_rx();
    t_stby();
    final_report();
  end
  // Whole run needs about 3500 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
